// file: rtl/step_dir_pkg.sv
// Purpose: Shared constants and types for the step/direction front end.
// Assumes: 200 MHz core clock.
// Notes:   Register map is byte addressed, one 32-bit word per register.
package step_dir_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ    = 200_000_000;
  localparam int FLASH_MS  = 250;
  localparam int PAUSE_MS  = 2000;
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STATUS  = 8'h04;
  localparam logic [7:0] ADR_POS     = 8'h08;
  localparam logic [7:0] ADR_SPR     = 8'h0C;
  localparam logic [7:0] ADR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h18;
  localparam logic [7:0] ADR_FAULT   = 8'h1C;

  localparam int CTRL_POS_CLR = 0;
  localparam int CTRL_FLT_CLR = 1;
  localparam int CTRL_HOLD    = 2;
  localparam int CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  localparam int IRQ_STEP = 0;
  localparam int IRQ_FLT  = 1;
  localparam int IRQ_REV  = 2;
  localparam int IRQ_W    = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam int NUM_FAULTS = 5;
  localparam logic [NUM_FAULTS-1:0] FAULT_RST = 5'h00;
  localparam logic [15:0] DEFAULT_SPR = 16'h0FA0;

  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ON    = 2'b01,
    FL_OFF   = 2'b10,
    FL_PAUSE = 2'b11
  } flash_state_e;

  // Index is the switch pattern with OFF read as 1, first switch the LSB.
  function automatic logic [15:0] steps_per_rev(input logic [3:0] off, input logic [15:0] dflt);
    logic [15:0] r;
    r = dflt;
    unique case (off)
      4'h0: r = dflt;
      4'h1: r = 16'h0320;
      4'h2: r = 16'h0640;
      4'h3: r = 16'h0C80;
      4'h4: r = 16'h1900;
      4'h5: r = 16'h3200;
      4'h6: r = 16'h6400;
      4'h7: r = 16'hC800;
      4'h8: r = 16'h03E8;
      4'h9: r = 16'h07D0;
      4'hA: r = 16'h0FA0;
      4'hB: r = 16'h1388;
      4'hC: r = 16'h1F40;
      4'hD: r = 16'h2710;
      4'hE: r = 16'h4E20;
      4'hF: r = 16'h9C40;
    endcase
    return r;
  endfunction

endpackage

// file: rtl/step_tracker.sv
// Purpose: Counts qualified step edges into a commanded position.
// Assumes: Pulse and direction inputs already synchronous to clk_i.
// Notes:   Phase wraps within one revolution at the selected resolution.
`timescale 1ns/100ps
`default_nettype none
module step_tracker #(
  parameter int POS_W = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             pulse_i,
  input  wire logic             dir_i,
  input  wire logic             sense_i,
  input  wire logic             edge_sel_i,
  input  wire logic             run_i,
  input  wire logic             pos_clr_i,
  input  wire logic [15:0]      spr_i,
  output logic      [POS_W-1:0] pos_o,
  output logic      [15:0]      phase_o,
  output logic                  step_o,
  output logic                  rev_o,
  output logic                  cw_o
);
  import step_dir_pkg::*;

  if (POS_W < 16) begin : g_chk
    $error("POS_W must be at least 16");
  end

  logic prev_q;
  logic armed_q;
  logic hit;
  logic cw;

  // The first sample after reset only arms the detector, so a level held at release is no edge.
  assign hit = armed_q & (edge_sel_i ? (prev_q & ~pulse_i) : (~prev_q & pulse_i));
  assign cw  = ~(dir_i ^ sense_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= pulse_i;
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o   <= '0;
      phase_o <= 16'h0000;
      step_o  <= 1'b0;
      rev_o   <= 1'b0;
      cw_o    <= 1'b0;
    end else begin
      step_o <= hit & run_i;
      rev_o  <= 1'b0;
      cw_o   <= cw;
      if (pos_clr_i) begin
        pos_o   <= '0;
        phase_o <= 16'h0000;
      end else if (hit && run_i) begin
        if (cw) begin
          pos_o <= pos_o + POS_W'(1);
          if (phase_o >= spr_i - 16'h0001) begin
            phase_o <= 16'h0000;
            rev_o   <= 1'b1;
          end else begin
            phase_o <= phase_o + 16'h0001;
          end
        end else begin
          pos_o <= pos_o - POS_W'(1);
          if (phase_o == 16'h0000 || phase_o >= spr_i) begin
            phase_o <= spr_i - 16'h0001;
            rev_o   <= 1'b1;
          end else begin
            phase_o <= phase_o - 16'h0001;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/fault_flasher.sv
// Purpose: Flashes the red LED a fault's count of times, then pauses.
// Assumes: code_i is 0 for no fault, otherwise the flash count.
// Notes:   The code is latched per group so a change never splits a group.
`timescale 1ns/100ps
`default_nettype none
module fault_flasher #(
  parameter int FLASH_CYC = 50_000_000,
  parameter int PAUSE_CYC = 400_000_000
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] code_i,
  output logic            led_o
);
  import step_dir_pkg::*;

  localparam int CW = $clog2(PAUSE_CYC + 1);

  if (FLASH_CYC < 1 || PAUSE_CYC < FLASH_CYC) begin : g_chk
    $error("need 1 <= FLASH_CYC <= PAUSE_CYC");
  end

  flash_state_e  state_q;
  logic [CW-1:0] cnt_q;
  logic [2:0]    left_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FL_IDLE;
      cnt_q   <= '0;
      left_q  <= 3'h0;
      led_o   <= 1'b0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
      unique case (state_q)
        FL_IDLE: begin
          cnt_q <= '0;
          if (code_i != 3'h0) begin
            left_q  <= code_i;
            state_q <= FL_ON;
            led_o   <= 1'b1;
          end
        end
        FL_ON: if (cnt_q == CW'(FLASH_CYC - 1)) begin
          cnt_q   <= '0;
          state_q <= FL_OFF;
          led_o   <= 1'b0;
          left_q  <= left_q - 3'h1;
        end
        FL_OFF: if (cnt_q == CW'(FLASH_CYC - 1)) begin
          cnt_q <= '0;
          if (left_q == 3'h0) begin
            state_q <= FL_PAUSE;
          end else begin
            state_q <= FL_ON;
            led_o   <= 1'b1;
          end
        end
        FL_PAUSE: if (cnt_q == CW'(PAUSE_CYC - 1)) begin
          cnt_q   <= '0;
          state_q <= FL_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/step_dir_fault_top.sv
// Purpose: Step/direction command front end with fault flash reporting.
// Assumes: All pins synchronous to clk_i; switch inputs are 1 when ON.
// Notes:   Registers reached over classic Wishbone, one word per register.
//
// Summary of operation
// - Four resolution switches pick steps per revolution; all on gives default.
// - Edge switch off counts rising step edges; on counts trailing edges.
// - Direction switch off means counter-clockwise for a high direction level; on means clockwise.
// - Overcurrent fault shows as one red flash per group.
// - Voltage reference fault shows as two red flashes per group.
// - Stored parameter load fault shows as three red flashes per group.
// - Overvoltage fault shows as four red flashes per group.
// - Position following error shows as five red flashes per group.
// - An unconnected enable input pair leaves the drive enabled.
`timescale 1ns/100ps
`default_nettype none
module step_dir_fault_top #(
  parameter int          POS_W     = 32,
  parameter int          FLASH_CYC = step_dir_pkg::FLASH_CYC,
  parameter int          PAUSE_CYC = step_dir_pkg::PAUSE_CYC,
  parameter logic [15:0] DFLT_SPR  = step_dir_pkg::DEFAULT_SPR
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Wishbone classic slave.
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  // Command pins and switches.
  input  wire logic                              step_pulse_in_i,
  input  wire logic                              direction_i,
  input  wire logic                              drive_enable_in_i,
  input  wire logic                              edge_select_switch_i,
  input  wire logic                              direction_sense_switch_i,
  input  wire logic [3:0]                        resolution_switch_i,
  // Fault sources from the servo and power sections.
  input  wire logic [step_dir_pkg::NUM_FAULTS-1:0] fault_i,
  // Outputs toward the servo loop and the panel.
  output logic      [POS_W-1:0]                  position_o,
  output logic                                   step_o,
  output logic                                   motor_cw_o,
  output logic                                   drive_enabled_o,
  output logic                                   fault_output_o,
  output logic                                   led_red_o,
  output logic                                   irq_o
);
  import step_dir_pkg::*;

  if (POS_W < 16 || POS_W > 32) begin : g_chk
    $error("POS_W must be 16 to 32");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [CTRL_W-1:0]     ctrl_q;
  logic [IRQ_W-1:0]      irq_st_q;
  logic [IRQ_W-1:0]      irq_en_q;
  logic [NUM_FAULTS-1:0] fault_q;
  logic [15:0]           spr_q;
  logic                  ack_q;
  logic [31:0]           rdat_q;
  logic                  req;
  logic                  wr;
  logic [31:0]           wmask;
  logic [31:0]           wval;
  logic                  pos_clr;
  logic                  flt_clr;
  logic                  run;
  logic [2:0]            code;
  logic [15:0]           phase;
  logic                  step_ev;
  logic                  rev_ev;
  logic                  flt_ev;
  logic [IRQ_W-1:0]      irq_set;
  logic [IRQ_W-1:0]      irq_clr;

  // ****************************************
  // Wishbone access
  // ****************************************
  // One wait state: ack rises the cycle after the strobe and drops the next.
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = req & wb_we_i;

  // Byte enables become a bit mask so partial writes leave other lanes alone.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
    wval = wb_dat_i & wmask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************
  // Control and command strobes
  // ****************************************
  assign pos_clr = wr && (wb_adr_i == ADR_CTRL) && wval[CTRL_POS_CLR];
  assign flt_clr = wr && (wb_adr_i == ADR_CTRL) && wval[CTRL_FLT_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      // Clear bits are strobes; only the hold bit is stored.
      ctrl_q <= {wb_dat_i[CTRL_HOLD], 2'b00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= IRQ_RST;
    end else if (wr && wb_adr_i == ADR_IRQ_EN && wb_sel_i[0]) begin
      irq_en_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // ****************************************
  // Resolution and enable
  // ****************************************
  // Switch settings are re-read every cycle so a change applies at the next step.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spr_q <= DFLT_SPR;
    end else begin
      spr_q <= steps_per_rev(~resolution_switch_i, DFLT_SPR);
    end
  end

  // Current through the enable pair disables; a floating pair carries none.
  assign run = ~drive_enable_in_i & ~ctrl_q[CTRL_HOLD];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_enabled_o <= 1'b0;
    end else begin
      drive_enabled_o <= run;
    end
  end

  // ****************************************
  // Step tracking
  // ****************************************
  step_tracker #(
    .POS_W (POS_W)
  ) u_track (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pulse_i    (step_pulse_in_i),
    .dir_i      (direction_i),
    .sense_i    (direction_sense_switch_i),
    .edge_sel_i (edge_select_switch_i),
    .run_i      (run),
    .pos_clr_i  (pos_clr),
    .spr_i      (spr_q),
    .pos_o      (position_o),
    .phase_o    (phase),
    .step_o     (step_ev),
    .rev_o      (rev_ev),
    .cw_o       (motor_cw_o)
  );

  assign step_o = step_ev;

  // ****************************************
  // Faults
  // ****************************************
  // Fault bits are sticky; a source still active re-sets its bit over a clear.
  assign flt_ev = |(fault_i & ~fault_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= FAULT_RST;
    end else if (flt_clr) begin
      fault_q <= fault_i;
    end else begin
      fault_q <= fault_q | fault_i;
    end
  end

  // Lowest index wins so the most urgent fault is the one flashed.
  always_comb begin
    code = 3'h0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (fault_q[i]) begin
        code = 3'(i + 1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_output_o <= 1'b0;
    end else begin
      fault_output_o <= |fault_q;
    end
  end

  fault_flasher #(
    .FLASH_CYC (FLASH_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flash (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .code_i (code),
    .led_o  (led_red_o)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_set = {rev_ev, flt_ev, step_ev};
  assign irq_clr = (wr && wb_adr_i == ADR_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

  // A set in the same cycle as its clear keeps the bit, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= IRQ_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st_q & irq_en_q);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CTRL:    rdat_q <= {29'h0, ctrl_q};
        ADR_STATUS:  rdat_q <= {24'h0, code, led_red_o, motor_cw_o,
                                fault_output_o, drive_enabled_o, run};
        ADR_POS:     rdat_q <= 32'(position_o);
        ADR_SPR:     rdat_q <= {phase, spr_q};
        ADR_IRQ_ST:  rdat_q <= {29'h0, irq_st_q};
        ADR_IRQ_EN:  rdat_q <= {29'h0, irq_en_q};
        ADR_FAULT:   rdat_q <= {27'h0, fault_q};
        default:     rdat_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verif/step_dir_fault_props.sv
// Purpose: Port-level checks on the step/direction front end.
// Assumes: Bound into step_dir_fault_top; one clock domain.
// Notes:   The flash length is counted in helper logic, not unrolled.
`timescale 1ns/100ps
`default_nettype none
module step_dir_fault_props #(
  parameter int POS_W     = 32,
  parameter int FLASH_CYC = 4
) (
  input wire logic                                 clk_i,
  input wire logic                                 rst_i,
  input wire logic                                 wb_cyc_i,
  input wire logic                                 wb_stb_i,
  input wire logic                                 wb_ack_o,
  input wire logic                                 step_pulse_in_i,
  input wire logic                                 direction_i,
  input wire logic                                 drive_enable_in_i,
  input wire logic                                 edge_select_switch_i,
  input wire logic                                 direction_sense_switch_i,
  input wire logic [step_dir_pkg::NUM_FAULTS-1:0] fault_i,
  input wire logic [POS_W-1:0]                     position_o,
  input wire logic                                 step_o,
  input wire logic                                 motor_cw_o,
  input wire logic                                 drive_enabled_o,
  input wire logic                                 fault_output_o,
  input wire logic                                 led_red_o
);
  logic [31:0] on_cnt_q;
  // Wide enough for the full-length flash, not only the short bench timing.
  always_ff @(posedge clk_i) begin
    if (rst_i || !led_red_o) begin
      on_cnt_q <= 32'h0000_0000;
    end else begin
      on_cnt_q <= on_cnt_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_held_off;
    drive_enable_in_i [*4];
  endsequence
  ack_after_take_a: assert property (s_take |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  step_edge_a: assert property (step_o |->
    $past(step_pulse_in_i) == !edge_select_switch_i && $past(step_pulse_in_i, 2) == edge_select_switch_i)
    else $error("step on wrong edge");
  rise_counted_a: assert property ($rose(step_pulse_in_i) && !edge_select_switch_i && drive_enabled_o |=> step_o)
    else $error("rising edge not counted");
  step_move_a: assert property (step_o |->
    position_o == $past(position_o) + (motor_cw_o ? POS_W'(1) : {POS_W{1'b1}}))
    else $error("position not moved by one step");
  cw_sense_a: assert property (step_o |-> motor_cw_o == !($past(direction_i) ^ direction_sense_switch_i))
    else $error("direction sense wrong");
  enable_off_a: assert property (drive_enable_in_i |=> !drive_enabled_o)
    else $error("drive enabled while enable driven");
  no_step_off_a: assert property (s_held_off |-> !step_o)
    else $error("step counted while disabled");
  alarm_raise_a: assert property (|fault_i |-> ##2 fault_output_o)
    else $error("alarm not raised");
  flash_len_a: assert property ($fell(led_red_o) |-> on_cnt_q == FLASH_CYC)
    else $error("flash length wrong");
endmodule
bind step_dir_fault_top step_dir_fault_props #(.POS_W(POS_W), .FLASH_CYC(FLASH_CYC)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .step_pulse_in_i, .direction_i, .drive_enable_in_i,
  .edge_select_switch_i, .direction_sense_switch_i, .fault_i, .position_o, .step_o, .motor_cw_o,
  .drive_enabled_o, .fault_output_o, .led_red_o);
`default_nettype wire

// file: verif/step_source.sv
// Purpose: Motion controller model issuing step and direction pulses.
// Assumes: Called from the bench thread on the bench clock.
// Notes:   Random widths cover prompt and slow controllers.
`timescale 1ns/100ps
`default_nettype none
module step_source (
  input  wire logic clk_i,
  output logic      pulse_o,
  output logic      dir_o,
  output logic      en_o
);
  initial begin
    pulse_o = 1'b0;
    dir_o   = 1'b0;
    en_o    = 1'b0;
  end
  // Direction settles a cycle ahead so the counted edge never sees it move.
  task automatic pulse(input logic d);
    int h;
    int l;
    h = 1 + $urandom % 3;
    l = 1 + $urandom % 3;
    @(posedge clk_i);
    dir_o <= d;
    @(posedge clk_i);
    pulse_o <= 1'b1;
    repeat (h) @(posedge clk_i);
    pulse_o <= 1'b0;
    repeat (l) @(posedge clk_i);
  endtask
  task automatic set_en(input logic v);
    @(posedge clk_i);
    en_o <= v;
  endtask
endmodule
`default_nettype wire

// file: verif/step_dir_command_and_fault_indicator_bench.sv
// Purpose: Self-checking bench for the step/direction front end.
// Assumes: Short flash timing parameters.
// Notes:   Monitors pop expected values noted by the drivers.
`timescale 1ns/100ps
`default_nettype none
module step_dir_command_and_fault_indicator_bench;
  import step_dir_pkg::*;
  localparam int FL = 4;
  localparam logic [15:0] SPR_TAB [16] = '{DEFAULT_SPR, 16'h0320, 16'h0640, 16'h0C80, 16'h1900, 16'h3200,
    16'h6400, 16'hC800, 16'h03E8, 16'h07D0, 16'h0FA0, 16'h1388, 16'h1F40, 16'h2710, 16'h4E20, 16'h9C40};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, edge_sel, sense, step_pulse_input, dir, en, dv;
  logic step_o, motor_cw_o, drive_enabled_o, fault_output_o, led_red_o, irq_o, led_p;
  logic [7:0]            wb_adr_i;
  logic [31:0]           wb_dat_i, wb_dat_o, position_o, exp_pos;
  logic [3:0]            res;
  logic [NUM_FAULTS-1:0] fault_i;
  logic [31:0]           pq[$], rq[$], fq[$];
  int                    n_errors, num_checks, nfl, low, n;
  step_source u_ctl (.clk_i(clk_i), .pulse_o(step_pulse_input), .dir_o(dir), .en_o(en));
  step_dir_fault_top #(.FLASH_CYC(FL), .PAUSE_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_pulse_in_i(step_pulse_input), .direction_i(dir),
    .drive_enable_in_i(en), .edge_select_switch_i(edge_sel), .direction_sense_switch_i(sense),
    .resolution_switch_i(res), .fault_i(fault_i), .position_o(position_o), .step_o(step_o),
    .motor_cw_o(motor_cw_o), .drive_enabled_o(drive_enabled_o), .fault_output_o(fault_output_o),
    .led_red_o(led_red_o), .irq_o(irq_o));
  // **********
  // Tasks
  // **********
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic stop_test();
    n_errors += pq.size() + rq.size() + fq.size();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // **********
  // Monitors and stimulus
  // **********
  always @(posedge clk_i) begin
    if (rst_i) begin
      nfl = 0;
      low = 0;
    end else begin
      if (step_o === 1'b1) cmp(position_o, pq.size() ? pq.pop_front() : 'x);
      if (wb_ack_o === 1'b1 && !wb_we_i) cmp(32'(wb_dat_o[15:0]), rq.size() ? rq.pop_front() : 'x);
      nfl += int'(led_red_o && !led_p);
      low = led_red_o ? 0 : low + 1;
      if (low == FL + 2 && nfl > 0) begin
        cmp(nfl, fq.size() ? fq.pop_front() : 'x);
        nfl = 0;
      end
    end
    led_p = led_red_o;
  end
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #(5 * 20000);
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(43548));
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, edge_sel, sense, res, fault_i} = '0;
    exp_pos = 32'h0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      res <= ~i[3:0];
      repeat (2) @(posedge clk_i);
      rq.push_back(SPR_TAB[i]);
      wb(1'b0, ADR_SPR, 32'h0);
    end
    wb(1'b1, 8'h24, $urandom);
    rq.push_back(32'h0);
    wb(1'b0, 8'h24, 32'h0);
    $display("test resolution done");
    for (int m = 0; m < 4; m++) begin
      {sense, edge_sel} <= m[1:0];
      repeat (3) @(posedge clk_i);
      repeat (2 + $urandom % 4) begin
        dv = $urandom;
        exp_pos += (dv ^ m[1]) ? 32'hFFFFFFFF : 32'h1;
        pq.push_back(exp_pos);
        u_ctl.pulse(dv);
      end
    end
    rq.push_back(32'(exp_pos[15:0]));
    wb(1'b0, ADR_POS, 32'h0);
    u_ctl.set_en(1'b1);
    repeat (2) u_ctl.pulse($urandom);
    cmp_flag(drive_enabled_o, 1'b0);
    u_ctl.set_en(1'b0);
    repeat (3) @(posedge clk_i);
    cmp_flag(drive_enabled_o, 1'b1);
    // Position clear and hold in one write; a held drive must count no edge.
    wb(1'b1, ADR_CTRL, 32'h5);
    rq.push_back(32'h0);
    wb(1'b0, ADR_POS, 32'h0);
    rq.push_back(32'h4);
    wb(1'b0, ADR_CTRL, 32'h0);
    u_ctl.pulse($urandom);
    cmp_flag(drive_enabled_o, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h0);
    $display("test stepping done");
    for (int k = 0; k < NUM_FAULTS; k++) begin
      {fault_i, rst_i} <= 6'h01;
      @(posedge clk_i);
      {fault_i, rst_i} <= {5'h01 << k, 1'b0};
      fq.push_back(k + 1);
      fq.push_back(k + 1);
      for (int j = 0; j < 4; j++) begin
        wb(1'b1, j == 3 ? ADR_IRQ_CLR : ADR_IRQ_EN, j == 1 ? 32'h0 : 32'h2);
        repeat (2) @(posedge clk_i);
        cmp_flag(irq_o, !j[0]);
      end
      cmp_flag(fault_output_o, 1'b1);
      rq.push_back(32'h01 << k);
      wb(1'b0, ADR_FAULT, 32'h0);
      n = 0;
      while (fq.size() > 0 && n < 500) begin
        @(posedge clk_i);
        n++;
      end
    end
    // Once the source is gone, a fault clear must empty the sticky bits.
    fault_i <= '0;
    wb(1'b1, ADR_CTRL, 32'h2);
    rq.push_back(32'h0);
    wb(1'b0, ADR_FAULT, 32'h0);
    cmp_flag(fault_output_o, 1'b0);
    $display("test faults done");
    stop_test();
  end
endmodule
`default_nettype wire
